// file: design/dcr_pkg.sv
// Purpose: constants and types for the display control register bank
// Assumes: 8-bit registers reached over a two-wire serial slave port
// Notes: reset values and writable masks are kept per register index
package dcr_pkg;
  // clock
  localparam int CLK_PERIOD_NS = 10;
  // slave address, upper six bits; the low bit follows the select pin
  localparam logic [5:0] SLAVE_ADDR_HI = 6'h17;
  // register indices
  localparam logic [7:0] IDX_STATUS = 8'h00;
  localparam logic [7:0] IDX_VIDEO_IN = 8'h01;
  localparam logic [7:0] IDX_DISP_MODE = 8'h02;
  localparam logic [7:0] IDX_ROW_TOP = 8'h03;
  localparam logic [7:0] IDX_ROW_BOT = 8'h04;
  localparam logic [7:0] IDX_RAMP_TIMING = 8'h05;
  localparam logic [7:0] IDX_RAMP_COMMON = 8'h06;
  localparam logic [7:0] IDX_RAMP_OFFSET = 8'h07;
  localparam logic [7:0] IDX_RAMP_FORCE = 8'h08;
  localparam logic [7:0] IDX_RSVD_09 = 8'h09;
  localparam logic [7:0] IDX_BIAS = 8'h0A;
  localparam logic [7:0] IDX_GAMMA = 8'h0B;
  localparam logic [7:0] IDX_POWER_DOWN = 8'h15;
  localparam int REG_COUNT = 12;
  // field positions
  localparam int BIT_SOFT_RESET = 5;
  localparam int BIT_DISPLAY_BLANK = 5;
  localparam int BIT_SLEEP_ALL = 7;
  // reset values
  localparam logic [7:0] RST_VIDEO_IN = 8'h03;
  localparam logic [7:0] RST_DISP_MODE = 8'h20;
  localparam logic [7:0] RST_ROW = 8'h06;
  localparam logic [7:0] RST_RAMP_TIMING = 8'h10;
  localparam logic [7:0] RST_RAMP_COMMON = 8'h06;
  localparam logic [7:0] RST_RAMP_FORCE = 8'h20;
  localparam logic [7:0] RST_BIAS = 8'h01;
  localparam logic [7:0] RST_GAMMA = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // writable bit masks
  localparam logic [7:0] WM_VIDEO_IN = 8'h2F;
  localparam logic [7:0] WM_DISP_MODE = 8'h3F;
  localparam logic [7:0] WM_FULL = 8'hFF;
  localparam logic [7:0] WM_RAMP_TIMING = 8'h70;
  localparam logic [7:0] WM_RAMP_FORCE = 8'h40;
  localparam logic [7:0] WM_BIAS = 8'h03;
  localparam logic [7:0] WM_GAMMA = 8'h08;
  localparam logic [7:0] WM_POWER_DOWN = 8'hFE;
  localparam logic [7:0] WM_NONE = 8'h00;
  // ramp return times
  localparam int RAMP_RETURN_SHORT_NS = 500;
  localparam int RAMP_RETURN_LONG_NS = 800;
  localparam logic [7:0] RAMP_RETURN_SHORT_CYC =
    8'(RAMP_RETURN_SHORT_NS / CLK_PERIOD_NS);
  localparam logic [7:0] RAMP_RETURN_LONG_CYC =
    8'(RAMP_RETURN_LONG_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic enable_active_high;
    logic field_even;
    logic vertical_sync_polarity;
    logic horizontal_sync_polarity;
    logic time_sequential_select;
    logic doubled_low_res_format;
    logic scan_type_select;
    logic row_scan_direction;
    logic column_scan_direction;
    logic [7:0] first_row_position;
    logic [7:0] last_row_position;
    logic ramp_return_time;
    logic [1:0] ramp_shift;
    logic [7:0] ramp_common;
    logic [3:0] ramp_offset_up;
    logic [3:0] ramp_offset_down;
    logic ramp_force_high;
    logic [1:0] bias_current_field;
    logic gamma_ref_half_select;
  } dcr_cfg_t;

  typedef struct packed {
    logic sleep_all;
    logic ramp_dac_off;
    logic bias_gen_off;
    logic top_ramp_buf_off;
    logic bot_ramp_buf_off;
    logic vcom_gen_off;
    logic temp_sensor_off;
  } dcr_pwr_t;

  function automatic logic [7:0] dcr_rst(input logic [7:0] idx);
    case (idx)
      IDX_VIDEO_IN: dcr_rst = RST_VIDEO_IN;
      IDX_DISP_MODE: dcr_rst = RST_DISP_MODE;
      IDX_ROW_TOP, IDX_ROW_BOT: dcr_rst = RST_ROW;
      IDX_RAMP_TIMING: dcr_rst = RST_RAMP_TIMING;
      IDX_RAMP_COMMON: dcr_rst = RST_RAMP_COMMON;
      IDX_RAMP_FORCE: dcr_rst = RST_RAMP_FORCE;
      IDX_BIAS: dcr_rst = RST_BIAS;
      IDX_GAMMA: dcr_rst = RST_GAMMA;
      default: dcr_rst = RST_ZERO;
    endcase
  endfunction

  function automatic logic [7:0] dcr_wmask(input logic [7:0] idx);
    case (idx)
      IDX_VIDEO_IN: dcr_wmask = WM_VIDEO_IN;
      IDX_DISP_MODE: dcr_wmask = WM_DISP_MODE;
      IDX_ROW_TOP, IDX_ROW_BOT, IDX_RAMP_COMMON, IDX_RAMP_OFFSET:
        dcr_wmask = WM_FULL;
      IDX_RAMP_TIMING: dcr_wmask = WM_RAMP_TIMING;
      IDX_RAMP_FORCE: dcr_wmask = WM_RAMP_FORCE;
      IDX_BIAS: dcr_wmask = WM_BIAS;
      IDX_GAMMA: dcr_wmask = WM_GAMMA;
      IDX_POWER_DOWN: dcr_wmask = WM_POWER_DOWN;
      default: dcr_wmask = WM_NONE;
    endcase
  endfunction
endpackage

// file: design/dcr_regs.sv
// Purpose: display control register bank behind a two-wire serial slave
// Assumes: scl and sda samples are synchronous to mclk and slow against it
// Notes: sda is open drain, the pin is pulled low while sda_oe is high
//
// How it works
// - sleep powers down all except serial port
// - sleep leaves every register value untouched
// - each block has its own power-down bit
// - power-up loads defaults, array held black
// - display blank bit resets one, test overrides
// - soft reset bit holds all other registers default
// - enable input active level select, reset low
// - field polarity select for enable period
// - sync polarity bits, both reset to one
// - time sequential 3D select, reset zero
// - reduced resolution doubles lines and pixels
// - progressive or interlaced scan select
// - row and column scan direction bits
// - first and last row positions, reset 06h
// - ramp return time 500 or 800 ns
// - ramp shift field, reset no delay
// - ramp offset nibbles up and down
// - ramp force high bit, reset zero
// - bias current field, reset 0.5nA code
// - gamma reference half select, reset one
// - write three bytes, read four bytes
// - answer only at address 010111 plus pin
// - sleep bit seven of power-down register
`timescale 1ns/1ps
module dcr_regs #(
  parameter logic [2:0] SILICON_REV = 3'h2 // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // serial port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic slave_address_select_pin,
  // device straps
  input wire logic aging_test_mode,
  // configuration out
  output dcr_pkg::dcr_cfg_t cfg,
  output dcr_pkg::dcr_pwr_t pwr,
  output logic display_blank,
  output logic [7:0] ramp_return_cycles
);

  if (dcr_pkg::REG_COUNT != 12) begin : g_chk
    $error("register count must be 12");
  end

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DACK, ST_REG, ST_RACK,
    ST_WR, ST_WACK, ST_RD, ST_RDACK
  } dcr_state_t;

  ////////////////////////////////////////////////////////////////////////
  // serial line sampling

  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign bus_start = scl_i & scl_q & sda_q & ~sda_i;
  assign bus_stop = scl_i & scl_q & ~sda_q & sda_i;

  ////////////////////////////////////////////////////////////////////////
  // serial transfer engine

  dcr_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic oe_q;
  logic wr_en_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_byte;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      oe_q <= 1'b0;
      wr_en_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_en_q <= 1'b0;
      if (bus_start) begin
        st_q <= ST_DEV;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (bus_stop) begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        case (st_q)
          ST_DEV, ST_REG, ST_WR: begin
            sh_q <= {sh_q[6:0], sda_i};
            cnt_q <= 4'(cnt_q + 4'h1);
          end
          ST_RD: cnt_q <= 4'(cnt_q + 4'h1);
          ST_RDACK: begin
            if (sda_i) begin
              st_q <= ST_IDLE;
            end else begin
              ptr_q <= 8'(ptr_q + 8'h01);
            end
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_q)
          ST_DEV: begin
            if (cnt_q == 4'h8) begin
              if (sh_q[7:1] == {dcr_pkg::SLAVE_ADDR_HI,
                                slave_address_select_pin}) begin
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= ST_DACK;
              end else begin
                st_q <= ST_IDLE;
              end
            end
          end
          ST_DACK: begin
            cnt_q <= 4'h0;
            if (rw_q) begin
              sh_q <= rd_byte;
              oe_q <= ~rd_byte[7];
              st_q <= ST_RD;
            end else begin
              oe_q <= 1'b0;
              st_q <= ST_REG;
            end
          end
          ST_REG: begin
            if (cnt_q == 4'h8) begin
              ptr_q <= sh_q;
              oe_q <= 1'b1;
              st_q <= ST_RACK;
            end
          end
          ST_RACK: begin
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            st_q <= ST_WR;
          end
          ST_WR: begin
            if (cnt_q == 4'h8) begin
              wr_en_q <= 1'b1;
              wr_addr_q <= ptr_q;
              wr_data_q <= sh_q;
              oe_q <= 1'b1;
              st_q <= ST_WACK;
            end
          end
          ST_WACK: begin
            oe_q <= 1'b0;
            cnt_q <= 4'h0;
            ptr_q <= 8'(ptr_q + 8'h01);
            st_q <= ST_WR;
          end
          ST_RD: begin
            if (cnt_q == 4'h8) begin
              oe_q <= 1'b0;
              st_q <= ST_RDACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
          ST_RDACK: begin
            cnt_q <= 4'h0;
            sh_q <= rd_byte;
            oe_q <= ~rd_byte[7];
            st_q <= ST_RD;
          end
          default: ;
        endcase
      end
    end
  end

  // the port stays alive in sleep, and pulls sda low during reset
  assign sda_o = 1'b0;
  assign sda_oe = oe_q | ~resetn;

  ////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] reg_q [0:dcr_pkg::REG_COUNT-1];
  logic [7:0] pd_q;
  logic soft_reset_bit;

  assign soft_reset_bit = reg_q[1][dcr_pkg::BIT_SOFT_RESET];

  // sleep never touches storage, only the power outputs
  always_ff @(posedge mclk) begin
    for (int i = 0; i < dcr_pkg::REG_COUNT; i++) begin
      if (!resetn) begin
        reg_q[i] <= dcr_pkg::dcr_rst(8'(i));
      end else if (wr_en_q && wr_addr_q == 8'(i) &&
                   (!soft_reset_bit || i == 1)) begin
        reg_q[i] <= (wr_data_q & dcr_pkg::dcr_wmask(8'(i))) |
                    (dcr_pkg::dcr_rst(8'(i)) &
                     ~dcr_pkg::dcr_wmask(8'(i)));
      end else if (soft_reset_bit && i != 1) begin
        reg_q[i] <= dcr_pkg::dcr_rst(8'(i));
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pd_q <= dcr_pkg::RST_ZERO;
    end else if (soft_reset_bit) begin
      pd_q <= dcr_pkg::RST_ZERO;
    end else if (wr_en_q && wr_addr_q == dcr_pkg::IDX_POWER_DOWN) begin
      pd_q <= wr_data_q & dcr_pkg::WM_POWER_DOWN;
    end
  end

  // read mux; unmapped indices read zero
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q == dcr_pkg::IDX_STATUS) begin
      rd_byte = {5'h00, SILICON_REV};
    end else if (ptr_q < 8'(dcr_pkg::REG_COUNT)) begin
      rd_byte = reg_q[ptr_q[3:0]];
    end else if (ptr_q == dcr_pkg::IDX_POWER_DOWN) begin
      rd_byte = pd_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration outputs

  always_comb begin
    cfg.enable_active_high = reg_q[1][3];
    cfg.field_even = reg_q[1][2];
    cfg.vertical_sync_polarity = reg_q[1][1];
    cfg.horizontal_sync_polarity = reg_q[1][0];
    cfg.time_sequential_select = reg_q[2][4];
    cfg.doubled_low_res_format = reg_q[2][3];
    cfg.scan_type_select = reg_q[2][2];
    cfg.row_scan_direction = reg_q[2][1];
    cfg.column_scan_direction = reg_q[2][0];
    cfg.first_row_position = reg_q[3];
    cfg.last_row_position = reg_q[4];
    cfg.ramp_return_time = reg_q[5][6];
    cfg.ramp_shift = reg_q[5][5:4];
    cfg.ramp_common = reg_q[6];
    cfg.ramp_offset_up = reg_q[7][7:4];
    cfg.ramp_offset_down = reg_q[7][3:0];
    cfg.ramp_force_high = reg_q[8][6];
    cfg.bias_current_field = reg_q[10][1:0];
    cfg.gamma_ref_half_select = reg_q[11][3];
  end

  // sleep forces every block off
  always_comb begin
    pwr.sleep_all = pd_q[dcr_pkg::BIT_SLEEP_ALL];
    pwr.ramp_dac_off = pd_q[6] | pwr.sleep_all;
    pwr.bias_gen_off = pd_q[5] | pwr.sleep_all;
    pwr.top_ramp_buf_off = pd_q[4] | pwr.sleep_all;
    pwr.bot_ramp_buf_off = pd_q[3] | pwr.sleep_all;
    pwr.vcom_gen_off = pd_q[2] | pwr.sleep_all;
    pwr.temp_sensor_off = pd_q[1] | pwr.sleep_all;
  end

  // blank until host clears it; test mode forces the array on
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      display_blank <= 1'b1;
    end else begin
      display_blank <= reg_q[2][dcr_pkg::BIT_DISPLAY_BLANK] &
                       ~aging_test_mode;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ramp_return_cycles <= dcr_pkg::RAMP_RETURN_SHORT_CYC;
    end else if (reg_q[5][6]) begin
      ramp_return_cycles <= dcr_pkg::RAMP_RETURN_LONG_CYC;
    end else begin
      ramp_return_cycles <= dcr_pkg::RAMP_RETURN_SHORT_CYC;
    end
  end

endmodule

// file: tb/dcr_host.sv
// Purpose: two-wire host model that configures the register bank
// Assumes: wire pulled up, host pulls low while sda_oe is high
// Notes: scl phases of four mclk, idle with scl high
`timescale 1ns/1ps
module dcr_host (
  // clock
  input wire logic mclk,
  // serial wire
  output logic scl,
  output logic sda_oe,
  input wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic put_bit(input logic b);
    sda_oe <= !b;
    tick(2);
    scl <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic get_bit(output logic b);
    sda_oe <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(3);
    b = sda;
    tick(1);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic start_cond();
    sda_oe <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_oe <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask
  task automatic stop_cond();
    sda_oe <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_oe <= 1'b0;
    tick(4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask
  task automatic get_byte(output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b);
      d[i] = b;
    end
    put_bit(1'b1);
  endtask
  // address, index, data
  task automatic write_reg(input logic sel, input logic [7:0] idx,
    input logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({dcr_pkg::SLAVE_ADDR_HI, sel, 1'b0}, a0);
    put_byte(idx, a1);
    put_byte(data, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
  // address, index, repeated start, address, data
  task automatic read_reg(input logic sel, input logic [7:0] idx,
    output logic [7:0] data, output logic ok);
    logic a0, a1, a2;
    start_cond();
    put_byte({dcr_pkg::SLAVE_ADDR_HI, sel, 1'b0}, a0);
    put_byte(idx, a1);
    start_cond();
    put_byte({dcr_pkg::SLAVE_ADDR_HI, sel, 1'b1}, a2);
    get_byte(data);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule

// file: tb/dcr_regs_asserts.sv
// Purpose: port checks for the display control register bank
// Assumes: one mclk domain, synchronous active-low reset
// Notes: bound to dcr_regs below
`timescale 1ns/1ps
module dcr_regs_asserts #(
  parameter logic [2:0] SILICON_REV = 3'h2 // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // serial port
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic slave_address_select_pin,
  // straps and outputs
  input wire logic aging_test_mode,
  input wire dcr_pkg::dcr_cfg_t cfg,
  input wire dcr_pkg::dcr_pwr_t pwr,
  input wire logic display_blank,
  input wire logic [7:0] ramp_return_cycles
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_line_pull;
    $rose(sda_oe);
  endsequence
  sequence s_line_hold;
    sda_oe [*4];
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_reset_defaults: assert property (
    $rose(resetn) |-> display_blank &&
    cfg.first_row_position == 8'h06 && cfg.last_row_position == 8'h06)
    else $error("defaults missing after reset");
  a_reset_video: assert property (
    $rose(resetn) |-> {cfg.enable_active_high,
    cfg.field_even, cfg.vertical_sync_polarity,
    cfg.horizontal_sync_polarity} == 4'h3) else $error("bad video reset");
  a_reset_ramp: assert property (
    $rose(resetn) |-> cfg.ramp_shift == 2'h1 &&
    !cfg.ramp_force_high && cfg.bias_current_field == 2'h1 &&
    cfg.gamma_ref_half_select) else $error("bad ramp reset");
  a_reset_power: assert property ($rose(resetn) |-> pwr == '0 &&
    ramp_return_cycles == 8'h32) else $error("bad power reset");
  a_blank_override: assert property ($past(aging_test_mode) &&
    $past(resetn) |-> !display_blank) else $error("test mode not shown");
  a_sleep_all_off: assert property (pwr.sleep_all |-> &pwr)
    else $error("sleep left a block on");
  a_sleep_keeps_cfg: assert property ($changed(pwr.sleep_all) |->
    $stable(cfg)) else $error("sleep altered settings");
  a_return_cycles: assert property ($past(resetn) |->
    ramp_return_cycles == ($past(cfg.ramp_return_time) ? 8'h50 : 8'h32))
    else $error("ramp return count wrong");
  a_drive_scl_low: assert property ($changed(sda_oe) &&
    $past(resetn) |-> !scl_i) else $error("data moved with scl high");
  a_pull_stands: assert property (s_line_pull |-> s_line_hold)
    else $error("data pull too short");
endmodule
bind dcr_regs dcr_regs_asserts #(.SILICON_REV(SILICON_REV)) u_chk (
  .mclk(mclk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe(sda_oe),
  .slave_address_select_pin(slave_address_select_pin),
  .aging_test_mode(aging_test_mode), .cfg(cfg), .pwr(pwr),
  .display_blank(display_blank), .ramp_return_cycles(ramp_return_cycles));

// file: tb/display_control_registers_tb.sv
// Purpose: self-checking bench of the display control register bank
// Assumes: host model on the serial wire, pull-up on sda
// Notes: one task per scenario
`timescale 1ns/1ps
`define CHK(a, b) begin \
  samples_checked++; \
  if ((a) !== (b)) begin \
    errors++; \
    $display("wrong value at %0t got %h exp %h", $time, (a), (b)); \
  end \
end
module display_control_registers_tb;
  localparam logic [2:0] SILICON_REVISION_FIELD = 3'h3; // arbitrary value
  logic mclk, resetn, scl, host_oe, sel_pin, aging, dut_o, dut_oe, blank;
  logic [7:0] ret_cyc;
  dcr_pkg::dcr_cfg_t cfg;
  dcr_pkg::dcr_cfg_t exp_cfg;
  dcr_pkg::dcr_pwr_t pwr;
  int errors = 0;
  int samples_checked = 0;
  wire logic sda = !(host_oe || (dut_oe && !dut_o));
  dcr_regs #(.SILICON_REV(SILICON_REVISION_FIELD)) uut (.mclk(mclk), .resetn(resetn),
    .scl_i(scl), .sda_i(sda), .sda_o(dut_o), .sda_oe(dut_oe),
    .slave_address_select_pin(sel_pin), .aging_test_mode(aging),
    .cfg(cfg), .pwr(pwr), .display_blank(blank),
    .ramp_return_cycles(ret_cyc));
  dcr_host host (.mclk(mclk), .scl(scl), .sda_oe(host_oe), .sda(sda));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [7:0] d;
    logic ok;
    logic [7:0] exp [12] = '{8'h03, 8'h03, 8'h20, 8'h06, 8'h06, 8'h10,
      8'h06, 8'h00, 8'h20, 8'h00, 8'h01, 8'h08};
    `CHK({blank, ret_cyc}, {1'b1, 8'h32});
    for (int i = 0; i < 12; i++) begin
      host.read_reg(1'b0, 8'(i), d, ok);
      `CHK({ok, d}, {1'b1, exp[i]});
    end
    host.read_reg(1'b0, 8'h15, d, ok);
    `CHK(d, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_fields();
    logic [7:0] d;
    logic ok, ok2;
    logic [23:0] tbl [13] = '{24'h010A0A, 24'h021515, 24'h039E9E,
      24'h042626, 24'h056F60, 24'h07A5A5, 24'h08FF60, 24'h09FF00,
      24'h0A0202, 24'h0BF700, 24'h00FF03, 24'h20FF00, 24'h065A5A};
    for (int i = 0; i < 13; i++) begin
      host.write_reg(1'b0, tbl[i][23:16], tbl[i][15:8], ok);
      host.read_reg(1'b0, tbl[i][23:16], d, ok2);
      `CHK({ok2, d}, {1'b1, tbl[i][7:0]});
    end
    exp_cfg = {9'h155, 8'h9E, 8'h26, 1'b1, 2'h2, 8'h5A, 8'hA5, 1'b1,
      2'h2, 1'b0};
    `CHK(cfg, exp_cfg);
    `CHK({blank, ret_cyc}, {1'b0, 8'h50});
    for (int k = 0; k < 3; k++) begin
      host.write_reg(1'b0, 8'h0A, 8'(k), ok);
      host.write_reg(1'b0, 8'h05, 8'(k << 4), ok);
      `CHK(cfg.bias_current_field, 2'(k));
      `CHK(cfg.ramp_shift, 2'(k));
    end
    exp_cfg.ramp_return_time = 1'b0;
    $display("test fields done");
  endtask
  task automatic test_sleep();
    logic [7:0] d;
    logic ok;
    host.write_reg(1'b0, 8'h15, 8'hFF, ok);
    host.read_reg(1'b0, 8'h15, d, ok);
    `CHK({d, pwr}, {8'hFE, 7'h7F});
    host.write_reg(1'b0, 8'h15, 8'h08, ok);
    `CHK(pwr, 7'h04);
    host.write_reg(1'b0, 8'h15, 8'h80, ok);
    host.read_reg(1'b0, 8'h02, d, ok);
    `CHK({ok, d, pwr}, {1'b1, 8'h15, 7'h7F});
    host.write_reg(1'b0, 8'h15, 8'h00, ok);
    `CHK({pwr, cfg}, {7'h00, exp_cfg});
    $display("test sleep done");
  endtask
  task automatic test_soft_reset();
    logic [7:0] d;
    logic ok;
    host.write_reg(1'b0, 8'h01, 8'h20, ok);
    host.write_reg(1'b0, 8'h03, 8'h11, ok);
    host.read_reg(1'b0, 8'h03, d, ok);
    `CHK({d, blank, cfg.first_row_position}, {8'h06, 1'b1, 8'h06});
    host.write_reg(1'b0, 8'h01, 8'h00, ok);
    host.read_reg(1'b0, 8'h02, d, ok);
    `CHK(d, 8'h20);
    $display("test soft reset done");
  endtask
  task automatic test_address();
    logic [7:0] d;
    logic ok, ok2;
    host.write_reg(1'b1, 8'h03, 8'h55, ok);
    host.read_reg(1'b0, 8'h03, d, ok2);
    `CHK({ok, d}, {1'b0, 8'h06});
    sel_pin <= 1'b1;
    host.write_reg(1'b1, 8'h03, 8'h55, ok);
    host.read_reg(1'b1, 8'h03, d, ok2);
    `CHK({ok, ok2, d}, {2'h3, 8'h55});
    sel_pin <= 1'b0;
    aging <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(blank, 1'b0);
    aging <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(blank, 1'b1);
    $display("test address and test mode done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    resetn = 1'b0;
    sel_pin = 1'b0;
    aging = 1'b0;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    test_reset();
    test_fields();
    test_sleep();
    test_soft_reset();
    test_address();
    report_and_stop();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    report_and_stop();
  end
endmodule
